// File: logic/aft_defines.svh
`ifndef AFT_DEFINES_SVH
`define AFT_DEFINES_SVH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define AFT_ADDR_R1_TARGET    8'h33
`define AFT_ADDR_LOCAL_TARGET 8'h34
`define AFT_ADDR_R2_TARGET    8'h35
`define AFT_ADDR_CTRL         8'h36
// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define AFT_TARGET_RESET      8'h64
`define AFT_CTRL_RESET        8'h00
`define AFT_RDATA_RESET       8'h00
// ----------------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------------
`define AFT_BIT_R2_DELAY_MSB  0
`define AFT_BIT_UV_GUARD      1
`define AFT_BIT_R1_CAPTURE    2
`define AFT_BIT_LOCAL_CAPTURE 3
`define AFT_BIT_R2_CAPTURE    4
`define AFT_BIT_R1_ADAPTIVE   5
`define AFT_BIT_LOCAL_ADAPT   6
`define AFT_BIT_R2_ADAPTIVE   7
// ----------------------------------------------------------------------------
// Timing and format constants
// ----------------------------------------------------------------------------
`define AFT_DELAY_BASE        11'h008
`define AFT_OFFSET64          9'h040
`endif

// File: logic/aft_pkg.sv
`default_nettype none
package aft_pkg;
  // Byte held by every register of this block
  typedef logic [7:0] aft_byte_t;
  // Undervoltage guard state
  typedef enum logic [0:0]
  {
    AFT_UV_NORMAL  = 1'b0,
    AFT_UV_GUARDED = 1'b1
  } aft_uv_state_e;
endpackage
`default_nettype wire

// File: logic/aft_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "aft_defines.svh"
module aft_channel
#(
  parameter int CNT_W = 11
)
(
  input  wire logic            core_clk_in,
  input  wire logic            rst_in,
  input  wire logic            target_wr_in,
  input  wire aft_pkg::aft_byte_t target_wdata_in,
  input  wire logic            lock_in,
  input  wire logic            capture_en_in,
  input  wire logic            alarm_edge_in,
  input  wire aft_pkg::aft_byte_t temp_in,
  input  wire logic            temp_valid_in,
  input  wire logic            twos_compl_in,
  input  wire logic            adaptive_en_in,
  input  wire logic            suspend_in,
  input  wire logic            monitor_tick_in,
  input  wire logic [2:0]      delay_code_in,
  input  wire aft_pkg::aft_byte_t low_limit_in,
  input  wire aft_pkg::aft_byte_t high_limit_in,
  input  wire aft_pkg::aft_byte_t fan_start_prog_in,
  output logic                 busy_out,
  output aft_pkg::aft_byte_t   target_out,
  output aft_pkg::aft_byte_t   fan_start_out
);
  // ----------------------------------------------------------------------------
  // Temperature format
  // ----------------------------------------------------------------------------
  // Map both formats onto one signed scale so limits compare correctly
  function automatic logic signed [8:0] to_sgn(input logic [7:0] v, input logic twos);
    to_sgn = twos ? $signed({v[7], v}) : $signed({1'b0, v} - `AFT_OFFSET64);
  endfunction

  aft_pkg::aft_byte_t temp_last_reg;
  logic [CNT_W-1:0]   cnt_reg;
  logic [CNT_W-1:0]   period;
  logic               run;
  logic               step;
  logic signed [8:0]  t_s;
  logic signed [8:0]  tgt_s;
  logic signed [8:0]  fs_s;

  assign period = CNT_W'(`AFT_DELAY_BASE << delay_code_in);
  assign run    = adaptive_en_in && !suspend_in;
  assign step   = run && monitor_tick_in && (cnt_reg == period - 1'b1);
  assign t_s    = to_sgn(temp_last_reg, twos_compl_in);
  assign tgt_s  = to_sgn(target_out, twos_compl_in);
  assign fs_s   = to_sgn(fan_start_out, twos_compl_in);
  assign busy_out = 1'b0;

  // Latest completed reading; capture never sees a half-done conversion
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      temp_last_reg <= 8'h00;
    else if (temp_valid_in)
      temp_last_reg <= temp_in;
  end

  // Target register; a capture wins over a host write in the same cycle
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      target_out <= `AFT_TARGET_RESET;
    else if (alarm_edge_in && capture_en_in)
      target_out <= temp_last_reg;
    else if (target_wr_in && !lock_in)
      target_out <= target_wdata_in;
  end

  // Monitoring-cycle counter between adjustments
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || !run)
      cnt_reg <= '0;
    else if (monitor_tick_in)
      cnt_reg <= step ? '0 : cnt_reg + 1'b1;
  end

  // Fan start temperature: follows program when idle, walks when adaptive
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      fan_start_out <= 8'h00;
    else if (!adaptive_en_in)
      fan_start_out <= fan_start_prog_in;
    else if (step && (t_s > tgt_s) && (fs_s > to_sgn(low_limit_in, twos_compl_in)))
      fan_start_out <= fan_start_out - 8'h01;
    else if (step && (t_s < tgt_s) && (fs_s < to_sgn(high_limit_in, twos_compl_in)))
      fan_start_out <= fan_start_out + 8'h01;
  end
endmodule
`default_nettype wire

// File: logic/aft_threshold_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "aft_defines.svh"
module aft_threshold_ctrl
(
  input  wire logic               core_clk_in,
  input  wire logic               rst_in,
  // Register port
  input  wire logic [7:0]         reg_addr_in,
  input  wire aft_pkg::aft_byte_t reg_wdata_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  output aft_pkg::aft_byte_t      reg_rdata_out,
  // Neighbouring configuration
  input  wire logic               lock_in,
  input  wire logic               twos_compl_in,
  input  wire logic               alert_en_in,
  input  wire logic [1:0]         remote2_delay_low_in,
  input  wire logic [2:0]         remote1_delay_in,
  input  wire logic [2:0]         local_delay_in,
  input  wire logic               monitor_tick_in,
  // Alarm pin and supply monitor
  input  wire logic               thermal_alarm_pin_n_in,
  input  wire aft_pkg::aft_byte_t core_supply_input_in,
  input  wire aft_pkg::aft_byte_t core_low_limit_in,
  input  wire logic               status_clear_in,
  input  wire logic               shutdown_req_in,
  // Temperature channels
  input  wire aft_pkg::aft_byte_t remote1_temp_in,
  input  wire logic               remote1_temp_valid_in,
  input  wire aft_pkg::aft_byte_t remote1_low_limit_in,
  input  wire aft_pkg::aft_byte_t remote1_high_limit_in,
  input  wire aft_pkg::aft_byte_t remote1_fan_start_prog_in,
  input  wire aft_pkg::aft_byte_t local_temp_in,
  input  wire logic               local_temp_valid_in,
  input  wire aft_pkg::aft_byte_t local_low_limit_in,
  input  wire aft_pkg::aft_byte_t local_high_limit_in,
  input  wire aft_pkg::aft_byte_t local_fan_start_prog_in,
  input  wire aft_pkg::aft_byte_t remote2_temp_in,
  input  wire logic               remote2_temp_valid_in,
  input  wire aft_pkg::aft_byte_t remote2_low_limit_in,
  input  wire aft_pkg::aft_byte_t remote2_high_limit_in,
  input  wire aft_pkg::aft_byte_t remote2_fan_start_prog_in,
  // Results
  output aft_pkg::aft_byte_t      remote1_fan_start_temp_out,
  output aft_pkg::aft_byte_t      local_fan_start_temp_out,
  output aft_pkg::aft_byte_t      remote2_fan_start_temp_out,
  output logic                    uv_status_out,
  output logic                    smbalert_n_out,
  output logic                    cpu_hot_monitor_en_out,
  output logic                    shutdown_out
);
  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  aft_pkg::aft_byte_t    ctrl_reg;
  aft_pkg::aft_byte_t    r1_target;
  aft_pkg::aft_byte_t    lc_target;
  aft_pkg::aft_byte_t    r2_target;
  aft_pkg::aft_byte_t    rdata_next;
  aft_pkg::aft_uv_state_e uv_state_reg;
  aft_pkg::aft_uv_state_e uv_state_next;
  logic                  alarm_s1_reg;
  logic                  alarm_s2_reg;
  logic                  alarm_s3_reg;
  logic                  alarm_edge;
  logic                  below_limit;
  logic                  guarded;
  logic                  wr_r1;
  logic                  wr_lc;
  logic                  wr_r2;
  logic                  wr_ctrl;

  // ----------------------------------------------------------------------------
  // Alarm pin synchroniser
  // ----------------------------------------------------------------------------
  // Pin is asynchronous and active low; stage one feeds stage two only
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      alarm_s1_reg <= 1'b0;
      alarm_s2_reg <= 1'b0;
      alarm_s3_reg <= 1'b0;
    end
    else
    begin
      alarm_s1_reg <= !thermal_alarm_pin_n_in;
      alarm_s2_reg <= alarm_s1_reg;
      alarm_s3_reg <= alarm_s2_reg;
    end
  end

  // A held alarm captures once, on its leading edge only
  assign alarm_edge = alarm_s2_reg && !alarm_s3_reg;

  // ----------------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------------
  assign wr_r1   = reg_wr_in && (reg_addr_in == `AFT_ADDR_R1_TARGET);
  assign wr_lc   = reg_wr_in && (reg_addr_in == `AFT_ADDR_LOCAL_TARGET);
  assign wr_r2   = reg_wr_in && (reg_addr_in == `AFT_ADDR_R2_TARGET);
  assign wr_ctrl = reg_wr_in && (reg_addr_in == `AFT_ADDR_CTRL);

  // Control register; lock makes it read-only while lock_in is high
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      ctrl_reg <= `AFT_CTRL_RESET;
    else if (wr_ctrl && !lock_in)
      ctrl_reg <= reg_wdata_in;
  end

  // Read mux; unmapped addresses read as zero
  always_comb
  begin
    rdata_next = reg_rdata_out;
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        `AFT_ADDR_R1_TARGET:    rdata_next = r1_target;
        `AFT_ADDR_LOCAL_TARGET: rdata_next = lc_target;
        `AFT_ADDR_R2_TARGET:    rdata_next = r2_target;
        `AFT_ADDR_CTRL:         rdata_next = ctrl_reg;
        default:                rdata_next = 8'h00;
      endcase
    end
  end

  // Read data held until the next read
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      reg_rdata_out <= `AFT_RDATA_RESET;
    else
      reg_rdata_out <= rdata_next;
  end

  // ----------------------------------------------------------------------------
  // Undervoltage guard
  // ----------------------------------------------------------------------------
  // Reading equal to the limit counts as recovered
  assign below_limit = core_supply_input_in < core_low_limit_in;
  assign guarded     = (uv_state_reg == aft_pkg::AFT_UV_GUARDED);

  // Guard state: entered only with the guard bit set
  always_comb
  begin
    uv_state_next = uv_state_reg;
    unique case (uv_state_reg)
      aft_pkg::AFT_UV_NORMAL:
        if (ctrl_reg[`AFT_BIT_UV_GUARD] && below_limit)
          uv_state_next = aft_pkg::AFT_UV_GUARDED;
      aft_pkg::AFT_UV_GUARDED:
        if (!ctrl_reg[`AFT_BIT_UV_GUARD] || !below_limit)
          uv_state_next = aft_pkg::AFT_UV_NORMAL;
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      uv_state_reg <= aft_pkg::AFT_UV_NORMAL;
    else
      uv_state_reg <= uv_state_next;
  end

  // Sticky status flag; a new set wins over a clear in the same cycle
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      uv_status_out <= 1'b0;
    else if (guarded)
      uv_status_out <= 1'b1;
    else if (status_clear_in)
      uv_status_out <= 1'b0;
  end

  // Alert follows the flag, gated by the alert enable
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      smbalert_n_out <= 1'b1;
    else
      smbalert_n_out <= !(uv_status_out && alert_en_in);
  end

  // Hot monitoring and shutdown both held off while guarded
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      cpu_hot_monitor_en_out <= 1'b1;
      shutdown_out           <= 1'b0;
    end
    else
    begin
      cpu_hot_monitor_en_out <= !guarded;
      // The raw condition also blocks, so a request in the drop cycle cannot slip through
      shutdown_out           <= shutdown_req_in && !guarded && !(ctrl_reg[`AFT_BIT_UV_GUARD] && below_limit);
    end
  end

  // ----------------------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------------------
  aft_channel u_remote1
  (
    .core_clk_in       (core_clk_in),
    .rst_in            (rst_in),
    .target_wr_in      (wr_r1),
    .target_wdata_in   (reg_wdata_in),
    .lock_in           (lock_in),
    .capture_en_in     (ctrl_reg[`AFT_BIT_R1_CAPTURE]),
    .alarm_edge_in     (alarm_edge),
    .temp_in           (remote1_temp_in),
    .temp_valid_in     (remote1_temp_valid_in),
    .twos_compl_in     (twos_compl_in),
    .adaptive_en_in    (ctrl_reg[`AFT_BIT_R1_ADAPTIVE]),
    .suspend_in        (guarded),
    .monitor_tick_in   (monitor_tick_in),
    .delay_code_in     (remote1_delay_in),
    .low_limit_in      (remote1_low_limit_in),
    .high_limit_in     (remote1_high_limit_in),
    .fan_start_prog_in (remote1_fan_start_prog_in),
    .busy_out          (),
    .target_out        (r1_target),
    .fan_start_out     (remote1_fan_start_temp_out)
  );

  aft_channel u_local
  (
    .core_clk_in       (core_clk_in),
    .rst_in            (rst_in),
    .target_wr_in      (wr_lc),
    .target_wdata_in   (reg_wdata_in),
    .lock_in           (lock_in),
    .capture_en_in     (ctrl_reg[`AFT_BIT_LOCAL_CAPTURE]),
    .alarm_edge_in     (alarm_edge),
    .temp_in           (local_temp_in),
    .temp_valid_in     (local_temp_valid_in),
    .twos_compl_in     (twos_compl_in),
    .adaptive_en_in    (ctrl_reg[`AFT_BIT_LOCAL_ADAPT]),
    .suspend_in        (guarded),
    .monitor_tick_in   (monitor_tick_in),
    .delay_code_in     (local_delay_in),
    .low_limit_in      (local_low_limit_in),
    .high_limit_in     (local_high_limit_in),
    .fan_start_prog_in (local_fan_start_prog_in),
    .busy_out          (),
    .target_out        (lc_target),
    .fan_start_out     (local_fan_start_temp_out)
  );

  // Remote 2 delay code takes its top bit from this control register
  aft_channel u_remote2
  (
    .core_clk_in       (core_clk_in),
    .rst_in            (rst_in),
    .target_wr_in      (wr_r2),
    .target_wdata_in   (reg_wdata_in),
    .lock_in           (lock_in),
    .capture_en_in     (ctrl_reg[`AFT_BIT_R2_CAPTURE]),
    .alarm_edge_in     (alarm_edge),
    .temp_in           (remote2_temp_in),
    .temp_valid_in     (remote2_temp_valid_in),
    .twos_compl_in     (twos_compl_in),
    .adaptive_en_in    (ctrl_reg[`AFT_BIT_R2_ADAPTIVE]),
    .suspend_in        (guarded),
    .monitor_tick_in   (monitor_tick_in),
    .delay_code_in     ({ctrl_reg[`AFT_BIT_R2_DELAY_MSB], remote2_delay_low_in}),
    .low_limit_in      (remote2_low_limit_in),
    .high_limit_in     (remote2_high_limit_in),
    .fan_start_prog_in (remote2_fan_start_prog_in),
    .busy_out          (),
    .target_out        (r2_target),
    .fan_start_out     (remote2_fan_start_temp_out)
  );

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence uv_entry_s;
    !guarded && ctrl_reg[`AFT_BIT_UV_GUARD] && below_limit;
  endsequence

  sequence uv_leave_s;
    guarded && !below_limit;
  endsequence

  property uv_entry_p;
    uv_entry_s |=> guarded ##1 (uv_status_out && !cpu_hot_monitor_en_out);
  endproperty

  property uv_restore_p;
    uv_leave_s |=> !guarded ##1 cpu_hot_monitor_en_out;
  endproperty

  uv_entry_a: assert property (uv_entry_p)
    else $error("undervoltage entry did not flag or suspend");

  uv_restore_a: assert property (uv_restore_p)
    else $error("functions not restored after supply recovery");

  alert_drive_a: assert property (uv_status_out && alert_en_in |=> !smbalert_n_out)
    else $error("alert not asserted for flagged undervoltage");

  alert_gate_a: assert property (!alert_en_in |=> smbalert_n_out)
    else $error("alert asserted while alerts disabled");

  shutdown_block_a: assert property (guarded |=> !shutdown_out)
    else $error("shutdown entered while guarded");

  ctrl_lock_a: assert property (wr_ctrl && lock_in |=> $stable(ctrl_reg))
    else $error("locked control register changed");

  ctrl_write_a: assert property (wr_ctrl && !lock_in |=> ctrl_reg == $past(reg_wdata_in))
    else $error("control write not stored");

  target_lock_a: assert property (wr_r1 && lock_in && !(alarm_edge && ctrl_reg[2]) |=> $stable(r1_target))
    else $error("locked target register changed");

  capture_off_a: assert property (alarm_edge && !ctrl_reg[3] && !wr_lc |=> $stable(lc_target))
    else $error("local target changed with capture off");

  alarm_once_a: assert property (alarm_edge |=> !alarm_edge [*2])
    else $error("alarm edge repeated");

  hold_idle_a: assert property (!ctrl_reg[5] |=> remote1_fan_start_temp_out == $past(remote1_fan_start_prog_in))
    else $error("fan start not following program with adaptive off");
endmodule
`default_nettype wire

// File: verification/aft_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Sensor front end: monitoring ticks and completed readings
// ----------------------------------------------------------------------------
module aft_sensor_model
(
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  output logic      tick_out,
  output logic      valid_out
);
  logic [1:0] phase_reg;
  // One monitoring cycle every four clocks keeps adaptive periods short
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      phase_reg <= 2'h0;
    else
      phase_reg <= phase_reg + 2'h1;
  end
  // Every tick also completes one reading per channel
  always_ff @(posedge core_clk_in)
  begin
    tick_out  <= !rst_in && (phase_reg == 2'h3);
    valid_out <= !rst_in && (phase_reg == 2'h3);
  end
endmodule
`default_nettype wire

// File: verification/aft_threshold_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "aft_defines.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; $display("BAD %0t mismatch", $time); end end
module aft_threshold_ctrl_bench;
  // --------------------------------------------------------------------------
  // Stimulus and observed signals, named after the ports
  // --------------------------------------------------------------------------
  logic core_clk_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, lock_in = 0;
  logic twos_compl_in = 1, alert_en_in = 1, thermal_alarm_pin_n_in = 1;
  logic status_clear_in = 0, shutdown_req_in = 0, monitor_tick_in, valid;
  logic remote1_temp_valid_in, local_temp_valid_in, remote2_temp_valid_in;
  logic [7:0] reg_addr_in = 8'h00;
  logic [1:0] remote2_delay_low_in = 2'h0;
  logic [2:0] remote1_delay_in = 3'h0, local_delay_in = 3'h0;
  aft_pkg::aft_byte_t reg_wdata_in = 8'h00, core_supply_input_in = 8'hff, core_low_limit_in = 8'h80;
  aft_pkg::aft_byte_t remote1_temp_in = 8'h51, local_temp_in = 8'h52, remote2_temp_in = 8'h53;
  aft_pkg::aft_byte_t remote1_low_limit_in = 8'h10, local_low_limit_in = 8'h10, remote2_low_limit_in = 8'h10;
  aft_pkg::aft_byte_t remote1_high_limit_in = 8'h7f, local_high_limit_in = 8'h7f, remote2_high_limit_in = 8'h7f;
  aft_pkg::aft_byte_t remote1_fan_start_prog_in = 8'h40, local_fan_start_prog_in = 8'h40;
  aft_pkg::aft_byte_t remote2_fan_start_prog_in = 8'h40, reg_rdata_out, v;
  aft_pkg::aft_byte_t remote1_fan_start_temp_out, local_fan_start_temp_out, remote2_fan_start_temp_out;
  logic uv_status_out, smbalert_n_out, cpu_hot_monitor_en_out, shutdown_out;
  int errors = 0, checks = 0, i;
  assign remote1_temp_valid_in = valid;
  assign local_temp_valid_in   = valid;
  assign remote2_temp_valid_in = valid;
  // 200 MHz clock
  always #2.5 core_clk_in = ~core_clk_in;
  aft_threshold_ctrl dut (.*);
  aft_sensor_model sensor (.core_clk_in(core_clk_in), .rst_in(rst_in), .tick_out(monitor_tick_in), .valid_out(valid));
  // --------------------------------------------------------------------------
  // Register port tasks
  // --------------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input aft_pkg::aft_byte_t d);
    @(posedge core_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in    <= 1'b0;
  endtask
  // Read data lands on the edge that takes the strobe; the task samples it one edge later
  task automatic rd(input logic [7:0] a, output aft_pkg::aft_byte_t d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in   <= 1'b0;
    @(posedge core_clk_in);
    d = reg_rdata_out;
  endtask
  task automatic complete_run;
    if (errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Cuts a hang short
  initial
  begin
    repeat (20000) @(posedge core_clk_in);
    errors++;
    complete_run();
  end
  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge core_clk_in);
    rst_in <= 1'b0;
    // Reset values, then one unmapped place
    for (i = 0; i < 5; i++)
    begin
      rd(8'(8'h33 + i), v);
      `CHK(v, (i < 3) ? 8'h64 : 8'h00)
    end
    // All written first, so any aliasing between registers shows
    for (i = 0; i < 4; i++)
      wr(8'(8'h33 + i), 8'(8'h11 * (i + 1)));
    for (i = 0; i < 4; i++)
    begin
      rd(8'(8'h33 + i), v);
      `CHK(v, 8'h11 * (i + 1))
    end
    // Capture on alarm; a pin held low must not capture again
    wr(`AFT_ADDR_CTRL, 8'h1c);
    thermal_alarm_pin_n_in <= 1'b0;
    repeat (6) @(posedge core_clk_in);
    remote1_temp_in <= 8'h61;
    repeat (10) @(posedge core_clk_in);
    thermal_alarm_pin_n_in <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      rd(8'(8'h33 + i), v);
      `CHK(v, 8'h51 + i)
    end
    // Only remote 1 capture left on
    wr(`AFT_ADDR_CTRL, 8'h04);
    thermal_alarm_pin_n_in <= 1'b0;
    repeat (6) @(posedge core_clk_in);
    thermal_alarm_pin_n_in <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      rd(8'(8'h33 + i), v);
      `CHK(v, (i == 0) ? 8'h61 : 8'h51 + i)
    end
    // Lock makes both kinds of register read-only
    lock_in <= 1'b1;
    wr(`AFT_ADDR_R1_TARGET, 8'h99);
    wr(`AFT_ADDR_CTRL, 8'hff);
    rd(`AFT_ADDR_R1_TARGET, v);
    `CHK(v, 8'h61)
    rd(`AFT_ADDR_CTRL, v);
    `CHK(v, 8'h04)
    lock_in <= 1'b0;
    // Guarded undervoltage with a pending shutdown request
    wr(`AFT_ADDR_CTRL, 8'h02);
    core_supply_input_in <= 8'h70;
    shutdown_req_in      <= 1'b1;
    repeat (6) @(posedge core_clk_in);
    `CHK(uv_status_out, 1'b1)
    `CHK(smbalert_n_out, 1'b0)
    `CHK(cpu_hot_monitor_en_out, 1'b0)
    `CHK(shutdown_out, 1'b0)
    core_supply_input_in <= 8'h90;
    repeat (6) @(posedge core_clk_in);
    `CHK(cpu_hot_monitor_en_out, 1'b1)
    `CHK(shutdown_out, 1'b1)
    shutdown_req_in <= 1'b0;
    // Sticky flag clears only once the supply is back; the alert then releases
    status_clear_in <= 1'b1;
    @(posedge core_clk_in);
    status_clear_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    `CHK(uv_status_out, 1'b0)
    `CHK(smbalert_n_out, 1'b1)
    // Adaptive: remote 1 code 0, remote 2 code 4 from its top bit
    remote1_temp_in <= 8'h50;
    remote2_temp_in <= 8'h70;
    wr(`AFT_ADDR_R1_TARGET, 8'h30);
    wr(`AFT_ADDR_R2_TARGET, 8'h30);
    wr(`AFT_ADDR_CTRL, 8'ha1);
    repeat (40) @(posedge core_clk_in);
    `CHK(remote1_fan_start_temp_out, 8'h3f)
    `CHK(local_fan_start_temp_out, 8'h40)
    `CHK(remote2_fan_start_temp_out, 8'h40)
    repeat (488) @(posedge core_clk_in);
    `CHK(remote2_fan_start_temp_out, 8'h3f)
    // Offset-64: 0x90 is hot here but cold as twos complement, so direction tells the format
    wr(`AFT_ADDR_CTRL, 8'h00);
    twos_compl_in   <= 1'b0;
    remote1_temp_in <= 8'h90;
    local_temp_in   <= 8'h20;
    wr(`AFT_ADDR_CTRL, 8'h60);
    repeat (40) @(posedge core_clk_in);
    `CHK(remote1_fan_start_temp_out, 8'h3f)
    `CHK(local_fan_start_temp_out, 8'h41)
    complete_run();
  end
endmodule
`default_nettype wire
